// [core/exec_map.svh]
// offsets, field positions, reset values and widths of the execution unit
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// status flag bit positions
`define SF_C 3'd0
`define SF_Z 3'd1
`define SF_N 3'd2
`define SF_V 3'd3
`define SF_S 3'd4
`define SF_H 3'd5
`define SF_T 3'd6
`define SF_I 3'd7

// low register of each pointer pair
`define PTR_X_BASE 4'ha
`define PTR_Y_BASE 4'hc
`define PTR_Z_BASE 4'he

// reset values
`define STATUS_RESET 8'h00
`define SP_RESET     16'h005f
`define GPR_RESET    8'h00

// widths
`define DATA_W  8
`define ADDR_W  16
`define IO_AW   6
`define GPR_N   16
`define SW_AW   5

// software port map: 0x00..0x0f general registers
`define SW_GPR_LAST 5'h0f
`define SW_STATUS   5'h10
`define SW_SP_LO    5'h11
`define SW_SP_HI    5'h12
`define SW_STATE    5'h13

// small constants
`define ONE_ADDR 16'h0001
`define ONE_BYTE 8'h01

`endif

// [core/exec_pkg.sv]
// types shared by the execution unit and its testbench
package exec_pkg;

    typedef enum logic [4:0] {
        idle_op, io_bit_clear_op, bit_to_flag_op, flag_to_bit_op,
        flag_set_op, flag_clear_op, global_irq_on_op, global_irq_off_op,
        register_copy_op, immediate_load_op, indirect_read_op, indirect_write_op,
        direct_read_op, direct_write_op, io_in_op, io_out_op,
        push_op, pop_op, break_op, sleep_op, watchdog_kick_op
    } op_t;

    typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_t;

    typedef enum logic [1:0] {amode_plain, amode_post_inc, amode_pre_dec} amode_t;

    typedef enum logic [1:0] {st_idle, st_hold, st_load_wb} state_t;

endpackage

// [core/regfile_if.sv]
// general register file ports between the execution unit and its storage
`timescale 1ns/10ps
`include "exec_map.svh"

interface regfile_if;
    logic [3:0]            rd_idx_a;
    logic [`DATA_W-1:0]    rd_data_a;
    logic [3:0]            rd_idx_b;
    logic [`DATA_W-1:0]    rd_data_b;
    logic [3:0]            rd_idx_c;
    logic [`DATA_W-1:0]    rd_data_c;
    logic [3:0]            ptr_base;
    logic [`ADDR_W-1:0]    ptr_val;
    logic                  wr_en;
    logic [3:0]            wr_idx;
    logic [`DATA_W-1:0]    wr_data;
    logic                  pw_en;
    logic [3:0]            pw_base;
    logic [`ADDR_W-1:0]    pw_data;

    modport owner (input rd_idx_a, rd_idx_b, rd_idx_c, ptr_base, wr_en, wr_idx, wr_data,
                   pw_en, pw_base, pw_data,
                   output rd_data_a, rd_data_b, rd_data_c, ptr_val);
    modport user  (output rd_idx_a, rd_idx_b, rd_idx_c, ptr_base, wr_en, wr_idx, wr_data,
                   pw_en, pw_base, pw_data,
                   input rd_data_a, rd_data_b, rd_data_c, ptr_val);
endinterface

// [core/gp_regs.sv]
// sixteen general registers with three byte reads and a pointer-pair port
`timescale 1ns/10ps
`include "exec_map.svh"

module gp_regs (
    input  logic        clk,
    input  logic        reset_n,
    regfile_if.owner    rf
);
    logic [`DATA_W-1:0] regs [`GPR_N];

    // combinational reads; pointer pair is low byte then high byte
    assign rf.rd_data_a = regs[rf.rd_idx_a];
    assign rf.rd_data_b = regs[rf.rd_idx_b];
    assign rf.rd_data_c = regs[rf.rd_idx_c];
    assign rf.ptr_val   = {regs[rf.ptr_base + 4'h1], regs[rf.ptr_base]};

    // byte write, then pair write; the caller never issues both at once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `GPR_N; i++) begin
                regs[i] <= `GPR_RESET;
            end
        end else begin
            if (rf.wr_en) begin
                regs[rf.wr_idx] <= rf.wr_data;
            end
            if (rf.pw_en) begin
                regs[rf.pw_base]        <= rf.pw_data[7:0];
                regs[rf.pw_base + 4'h1] <= rf.pw_data[15:8];
            end
        end
    end
endmodule // gp_regs

// [core/exec_unit.sv]
// execution of bit, flag, data-transfer and control instructions
`timescale 1ns/10ps
`include "exec_map.svh"

// Notes on behaviour
// - io bit clear, flags kept, one cycle
// - register bit copied into transfer flag
// - transfer flag into register bit, flags kept
// - flag set/clear touches only its bit
// - load then pointer plus one, two cycles
// - pointer minus one then load, two cycles
// - store then pointer plus one, one cycle
// - pointer minus one then store, two cycles
// - direct store and load, one cycle each
// - io in and out, one cycle, flags kept
// - push onto stack in two cycles
// - pop from stack in two cycles
// - plain indirect store at pointer, one cycle
module exec_unit
    import exec_pkg::*;
(
    input  logic                clk,
    input  logic                reset_n,
    input  logic                op_valid,
    input  op_t                 op,
    input  logic [3:0]          op_rd,
    input  logic [3:0]          op_rr,
    input  logic [2:0]          op_bit,
    input  ptr_t                op_ptr,
    input  amode_t              op_mode,
    input  logic [`DATA_W-1:0]  op_imm,
    input  logic [`ADDR_W-1:0]  op_addr,
    output logic                op_ready,
    output logic                mem_re,
    output logic [`ADDR_W-1:0]  mem_raddr,
    input  logic [`DATA_W-1:0]  mem_rdata,
    output logic                mem_we,
    output logic [`ADDR_W-1:0]  mem_waddr,
    output logic [`DATA_W-1:0]  mem_wdata,
    output logic                io_re,
    output logic [`IO_AW-1:0]   io_raddr,
    input  logic [`DATA_W-1:0]  io_rdata,
    output logic                io_we,
    output logic [`IO_AW-1:0]   io_waddr,
    output logic [`DATA_W-1:0]  io_wdata,
    output logic [`DATA_W-1:0]  status_flags,
    output logic                watchdog_kick,
    output logic                sleep_req,
    output logic                break_req,
    input  logic [`SW_AW-1:0]   sw_addr,
    input  logic [`DATA_W-1:0]  sw_wdata,
    input  logic                sw_we,
    input  logic                sw_re,
    output logic [`DATA_W-1:0]  sw_rdata
);
    regfile_if rf ();

    state_t              state;
    logic [`ADDR_W-1:0]  sp;
    logic                accept;
    logic [`ADDR_W-1:0]  ptr_inc;
    logic [`ADDR_W-1:0]  ptr_dec;
    logic                sw_gpr_wr;
    logic [3:0]          pend_rd;
    logic [`DATA_W-1:0]  pend_data;
    logic                pend_ptr_en;
    logic [3:0]          pend_ptr_base;
    logic [`ADDR_W-1:0]  pend_ptr_val;
    logic                bst_bit;

    // low register index of a pointer pair
    function automatic logic [3:0] ptr_base_of(input ptr_t p);
        case (p)
            ptr_x:   ptr_base_of = `PTR_X_BASE;
            ptr_y:   ptr_base_of = `PTR_Y_BASE;
            default: ptr_base_of = `PTR_Z_BASE;
        endcase
    endfunction

    // one byte with a single bit replaced
    function automatic logic [`DATA_W-1:0] put_bit(input logic [`DATA_W-1:0] d, input logic [2:0] idx,
                                                  input logic v);
        logic [`DATA_W-1:0] m;
        m = `ONE_BYTE << idx;
        put_bit = v ? (d | m) : (d & ~m);
    endfunction

    gp_regs u_regs (
        .clk     (clk),
        .reset_n (reset_n),
        .rf      (rf.owner)
    );

    // handshake and pointer arithmetic
    assign op_ready     = (state == st_idle);
    assign accept       = op_valid && op_ready;
    assign rf.rd_idx_a  = op_rd;
    assign rf.rd_idx_b  = op_rr;
    assign rf.rd_idx_c  = sw_addr[3:0];
    assign rf.ptr_base  = ptr_base_of(op_ptr);
    assign ptr_inc      = rf.ptr_val + `ONE_ADDR;
    assign ptr_dec      = rf.ptr_val - `ONE_ADDR;
    assign sw_gpr_wr    = sw_we && (sw_addr <= `SW_GPR_LAST) && op_ready && !op_valid;
    assign bst_bit      = rf.rd_data_b[op_bit];

    // combinational read requests, answered in the same cycle
    always_comb begin
        mem_re    = 1'b0;
        mem_raddr = rf.ptr_val;
        io_re     = accept && (op == io_in_op || op == io_bit_clear_op);
        io_raddr  = op_addr[`IO_AW-1:0];
        if (accept) begin
            case (op)
                direct_read_op: begin
                    mem_re    = 1'b1;
                    mem_raddr = op_addr;
                end
                indirect_read_op: begin
                    mem_re    = 1'b1;
                    mem_raddr = (op_mode == amode_pre_dec) ? ptr_dec : rf.ptr_val;
                end
                pop_op: begin
                    mem_re    = 1'b1;
                    mem_raddr = sp + `ONE_ADDR;
                end
                default: mem_re = 1'b0;
            endcase
        end
    end

    // register byte write: pending load, accepted op, then software
    always_comb begin
        rf.wr_en   = 1'b0;
        rf.wr_idx  = op_rd;
        rf.wr_data = `GPR_RESET;
        if (state == st_load_wb) begin
            rf.wr_en   = 1'b1;
            rf.wr_idx  = pend_rd;
            rf.wr_data = pend_data;
        end else if (accept) begin
            rf.wr_en = 1'b1;
            case (op)
                register_copy_op:  rf.wr_data = rf.rd_data_b;
                immediate_load_op: rf.wr_data = op_imm;
                io_in_op:          rf.wr_data = io_rdata;
                direct_read_op:    rf.wr_data = mem_rdata;
                pop_op:            rf.wr_data = mem_rdata;
                flag_to_bit_op:    rf.wr_data = put_bit(rf.rd_data_a, op_bit, status_flags[`SF_T]);
                indirect_read_op: begin
                    rf.wr_en   = (op_mode != amode_pre_dec);
                    rf.wr_data = mem_rdata;
                end
                default:           rf.wr_en = 1'b0;
            endcase
        end else if (sw_gpr_wr) begin
            rf.wr_en   = 1'b1;
            rf.wr_idx  = sw_addr[3:0];
            rf.wr_data = sw_wdata;
        end
    end

    // pointer pair write, never in the same cycle as a byte write
    always_comb begin
        rf.pw_en   = 1'b0;
        rf.pw_base = ptr_base_of(op_ptr);
        rf.pw_data = ptr_inc;
        if (state == st_hold && pend_ptr_en) begin
            rf.pw_en   = 1'b1;
            rf.pw_base = pend_ptr_base;
            rf.pw_data = pend_ptr_val;
        end else if (accept && op == indirect_read_op && op_mode == amode_pre_dec) begin
            rf.pw_en   = 1'b1;
            rf.pw_data = ptr_dec;
        end else if (accept && op == indirect_write_op && op_mode != amode_plain) begin
            rf.pw_en   = 1'b1;
            rf.pw_data = (op_mode == amode_post_inc) ? ptr_inc : ptr_dec;
        end
    end

    // sequencer: two-cycle ops hold the issue slot for one more cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (accept) begin
                        case (op)
                            indirect_read_op: begin
                                if (op_mode == amode_post_inc) begin
                                    state <= st_hold;
                                end else if (op_mode == amode_pre_dec) begin
                                    state <= st_load_wb;
                                end
                            end
                            indirect_write_op: begin
                                if (op_mode == amode_pre_dec) begin
                                    state <= st_hold;
                                end
                            end
                            push_op: state <= st_hold;
                            pop_op:  state <= st_hold;
                            default: state <= st_idle;
                        endcase
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // values carried into the second cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_rd       <= 4'h0;
            pend_data     <= `GPR_RESET;
            pend_ptr_en   <= 1'b0;
            pend_ptr_base <= `PTR_X_BASE;
            pend_ptr_val  <= 16'h0000;
        end else begin
            pend_ptr_en <= accept && op == indirect_read_op && op_mode == amode_post_inc;
            if (accept) begin
                pend_rd       <= op_rd;
                pend_data     <= mem_rdata;
                pend_ptr_base <= ptr_base_of(op_ptr);
                pend_ptr_val  <= ptr_inc;
            end
        end
    end

    // registered data-space writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_we    <= 1'b0;
            mem_waddr <= 16'h0000;
            mem_wdata <= `GPR_RESET;
        end else begin
            mem_we <= accept && (op == indirect_write_op || op == direct_write_op || op == push_op);
            if (accept) begin
                mem_wdata <= rf.rd_data_b;
                case (op)
                    direct_write_op:   mem_waddr <= op_addr;
                    push_op:           mem_waddr <= sp;
                    indirect_write_op: mem_waddr <= (op_mode == amode_pre_dec) ? ptr_dec : rf.ptr_val;
                    default:           mem_waddr <= mem_waddr;
                endcase
            end
        end
    end

    // registered io writes; bit clear is read-modify-write in one cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            io_we    <= 1'b0;
            io_waddr <= {`IO_AW{1'b0}};
            io_wdata <= `GPR_RESET;
        end else begin
            io_we <= accept && (op == io_out_op || op == io_bit_clear_op);
            if (accept) begin
                io_waddr <= op_addr[`IO_AW-1:0];
                io_wdata <= (op == io_bit_clear_op) ? put_bit(io_rdata, op_bit, 1'b0) : rf.rd_data_b;
            end
        end
    end

    // status flags; a flag op in the same cycle wins over a software write on the bit it changes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_flags <= `STATUS_RESET;
        end else begin
            if (sw_we && sw_addr == `SW_STATUS) begin
                status_flags <= sw_wdata;
            end
            if (accept) begin
                case (op)
                    bit_to_flag_op:    status_flags[`SF_T] <= bst_bit;
                    flag_set_op:       status_flags[op_bit] <= 1'b1;
                    flag_clear_op:     status_flags[op_bit] <= 1'b0;
                    global_irq_on_op:  status_flags[`SF_I] <= 1'b1;
                    global_irq_off_op: status_flags[`SF_I] <= 1'b0;
                    default: begin
                    end // other ops keep any software write of this cycle
                endcase
            end
        end
    end

    // stack pointer: push writes then decrements, pop increments then reads
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sp <= `SP_RESET;
        end else if (accept && op == push_op) begin
            sp <= sp - `ONE_ADDR;
        end else if (accept && op == pop_op) begin
            sp <= sp + `ONE_ADDR;
        end else if (sw_we && sw_addr == `SW_SP_LO) begin
            sp[7:0] <= sw_wdata;
        end else if (sw_we && sw_addr == `SW_SP_HI) begin
            sp[15:8] <= sw_wdata;
        end
    end

    // control pulses; idle op touches nothing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_kick <= 1'b0;
            sleep_req     <= 1'b0;
            break_req     <= 1'b0;
        end else begin
            watchdog_kick <= accept && op == watchdog_kick_op;
            sleep_req     <= accept && op == sleep_op;
            break_req     <= accept && op == break_op;
        end
    end

    // software read port, data in the following cycle only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_rdata <= `GPR_RESET;
        end else if (sw_re) begin
            if (sw_addr <= `SW_GPR_LAST) begin
                sw_rdata <= rf.rd_data_c;
            end else begin
                case (sw_addr)
                    `SW_STATUS: sw_rdata <= status_flags;
                    `SW_SP_LO:  sw_rdata <= sp[7:0];
                    `SW_SP_HI:  sw_rdata <= sp[15:8];
                    `SW_STATE:  sw_rdata <= {7'h00, !op_ready};
                    default:    sw_rdata <= `GPR_RESET;
                endcase
            end
        end else begin
            sw_rdata <= `GPR_RESET;
        end
    end

    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_cbi_clears_bit: assert property (accept && op == io_bit_clear_op && !sw_we |=>
        io_we && io_wdata == put_bit($past(io_rdata), $past(op_bit), 1'b0) && $stable(status_flags) && op_ready)
        else $error("io bit clear wrong");
    a_bst_copies_t: assert property (accept && op == bit_to_flag_op && !sw_we |=>
        status_flags[`SF_T] == $past(bst_bit) && status_flags[5:0] == $past(status_flags[5:0]))
        else $error("bit to flag wrong");
    a_bld_keeps_flags: assert property (accept && op == flag_to_bit_op && !sw_we |=>
        $stable(status_flags))
        else $error("flag to bit changed flags");
    a_flag_set_one: assert property (accept && op == flag_set_op && !sw_we |=>
        status_flags == put_bit($past(status_flags), $past(op_bit), 1'b1))
        else $error("flag set wrong");
    a_ld_post_inc: assert property (accept && op == indirect_read_op && op_mode == amode_post_inc |=>
        !op_ready && rf.pw_en && rf.pw_data == $past(ptr_inc) ##1 op_ready)
        else $error("post increment load wrong");
    a_ld_pre_dec: assert property (accept && op == indirect_read_op && op_mode == amode_pre_dec |->
        mem_raddr == ptr_dec ##1 (state == st_load_wb && rf.wr_data == $past(mem_rdata)) ##1 op_ready)
        else $error("pre decrement load wrong");
    a_st_post_inc: assert property (accept && op == indirect_write_op && op_mode == amode_post_inc |=>
        mem_we && mem_waddr == $past(rf.ptr_val) && op_ready)
        else $error("post increment store wrong");
    a_st_pre_dec: assert property (accept && op == indirect_write_op && op_mode == amode_pre_dec |=>
        mem_we && mem_waddr == $past(ptr_dec) && !op_ready ##1 op_ready)
        else $error("pre decrement store wrong");
    a_direct_write: assert property (accept && op == direct_write_op |=>
        mem_we && mem_waddr == $past(op_addr) && mem_wdata == $past(rf.rd_data_b))
        else $error("direct store wrong");
    a_push_two: assert property (accept && op == push_op |=>
        mem_we && mem_waddr == $past(sp) && !op_ready ##1 op_ready)
        else $error("push wrong");
    a_pop_two: assert property (accept && op == pop_op |->
        mem_raddr == sp + `ONE_ADDR ##1 !op_ready ##1 op_ready)
        else $error("pop wrong");

    c_pre_dec_load: cover property (accept && op == indirect_read_op && op_mode == amode_pre_dec);
    c_push_then_pop: cover property (accept && op == push_op ##2 accept && op == pop_op);
    c_back_to_back: cover property (accept && op == direct_write_op ##1 accept && op == io_out_op);
endmodule // exec_unit

// [verif/data_space_model.sv]
// data memory, io space and stack standing behind the execution unit
`timescale 1ns/10ps
`include "exec_map.svh"

module data_space_model (
    input  logic               clk,
    input  logic               mem_re,
    input  logic [`ADDR_W-1:0] mem_raddr,
    output logic [`DATA_W-1:0] mem_rdata,
    input  logic               mem_we,
    input  logic [`ADDR_W-1:0] mem_waddr,
    input  logic [`DATA_W-1:0] mem_wdata,
    input  logic               io_re,
    input  logic [`IO_AW-1:0]  io_raddr,
    output logic [`DATA_W-1:0] io_rdata,
    input  logic               io_we,
    input  logic [`IO_AW-1:0]  io_waddr,
    input  logic [`DATA_W-1:0] io_wdata
);
    logic [`DATA_W-1:0] mem [256];
    logic [`DATA_W-1:0] io [64];
    logic [`DATA_W-1:0] churn = 8'h00;

    // each memory cell starts as the inverse of its address, so a wrong address shows; io cells start at zero
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
        for (int i = 0; i < 64; i++) io[i] = 8'h00;
    end

    // writes land at the edge; idle answer lines wander every cycle
    always @(posedge clk) begin
        churn <= churn + 8'h3b;
        if (mem_we) mem[mem_waddr[7:0]] <= mem_wdata;
        if (io_we) io[io_waddr] <= io_wdata;
    end

    // same-cycle read answers, only while a read is asked for
    assign mem_rdata = mem_re ? mem[mem_raddr[7:0]] : churn;
    assign io_rdata  = io_re ? io[io_raddr] : ~churn;
endmodule // data_space_model

// [verif/tb_bit_flag_and_data_transfer_ops.sv]
// self-checking bench for the execution unit
`timescale 1ns/10ps
`include "exec_map.svh"

module tb_bit_flag_and_data_transfer_ops import exec_pkg::*; ();
    typedef struct {
        op_t o; logic [4:0] ca; logic [7:0] ex; logic [3:0] d, s; logic [2:0] b;
        logic bz; logic [7:0] k; logic [15:0] a; ptr_t p; amode_t m;
    } row_t;
    logic        clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, sw_we = 1'b0, sw_re = 1'b0;
    op_t         op = idle_op;
    ptr_t        op_ptr = ptr_x;
    amode_t      op_mode = amode_plain;
    logic [3:0]  op_rd = 4'h0, op_rr = 4'h0;
    logic [2:0]  op_bit = 3'h0;
    logic [7:0]  op_imm = 8'h00, sw_wdata = 8'h00, mem_rdata, io_rdata, mem_wdata, io_wdata, status_flags, sw_rdata;
    logic [15:0] op_addr = 16'h0000, mem_raddr, mem_waddr;
    logic [5:0]  io_raddr, io_waddr;
    logic [4:0]  sw_addr = 5'h00;
    logic        op_ready, mem_re, mem_we, io_re, io_we, watchdog_kick, sleep_req, break_req;
    int          fails = 0, compares = 0, cycles = 0;
    row_t        rows [$];

    exec_unit u_dut (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op(op), .op_rd(op_rd), .op_rr(op_rr),
        .op_bit(op_bit), .op_ptr(op_ptr), .op_mode(op_mode), .op_imm(op_imm), .op_addr(op_addr),
        .op_ready(op_ready), .mem_re(mem_re), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_we(mem_we),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .io_re(io_re), .io_raddr(io_raddr), .io_rdata(io_rdata),
        .io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata), .status_flags(status_flags),
        .watchdog_kick(watchdog_kick), .sleep_req(sleep_req), .break_req(break_req), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata));
    data_space_model u_mem (.clk(clk), .mem_re(mem_re), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
        .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .io_re(io_re), .io_raddr(io_raddr),
        .io_rdata(io_rdata), .io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata));

    // 100 MHz clock and a ceiling on the run length
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // compare a byte, and a single flag
    task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(string n, logic e, logic g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask

    function automatic row_t mk(op_t o, logic [4:0] ca, logic [7:0] ex, logic [3:0] d = 0, logic [3:0] s = 0,
                                logic [2:0] b = 0, logic bz = 0, logic [7:0] k = 0, logic [15:0] a = 0,
                                ptr_t p = ptr_x, amode_t m = amode_plain);
        mk = '{o, ca, ex, d, s, b, bz, k, a, p, m};
    endfunction

    // software port: one-cycle strobes, read data in the following cycle only
    task automatic wr(logic [4:0] a, logic [7:0] v);
        sw_we <= 1'b1; sw_addr <= a; sw_wdata <= v;
        @(posedge clk);
        sw_we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [4:0] a, logic [7:0] e);
        sw_re <= 1'b1; sw_addr <= a;
        @(posedge clk);
        sw_re <= 1'b0;
        @(negedge clk);
        chk8("sw_rdata", e, sw_rdata);
        @(posedge clk);
    endtask

    // hold the op until taken, then check busy time and control pulses
    task automatic run(row_t r);
        op_valid <= 1'b1; op <= r.o; op_rd <= r.d; op_rr <= r.s; op_bit <= r.b;
        op_imm <= r.k; op_addr <= r.a; op_ptr <= r.p; op_mode <= r.m;
        do @(negedge clk); while (op_ready !== 1'b1);
        @(posedge clk);
        op_valid <= 1'b0;
        @(negedge clk);
        chk1("op_ready", !r.bz, op_ready);
        chk8("pulses", {5'h00, r.o == sleep_op, r.o == break_op, r.o == watchdog_kick_op},
             {5'h00, sleep_req, break_req, watchdog_kick});
        @(posedge clk);
        rd(r.ca, r.ex);
    endtask

    initial begin
        logic [7:0] st;
        rows = '{mk(immediate_load_op, 5'h01, 8'ha5, 1, , , , 8'ha5),
            mk(immediate_load_op, 5'h02, 8'h3c, 2, , , , 8'h3c),
            mk(register_copy_op, 5'h06, 8'h3c, 6, 2),
            mk(bit_to_flag_op, 5'h10, 8'h40, 0, 1, 5),
            mk(immediate_load_op, 5'h0a, 8'h20, 10, , , , 8'h20),
            mk(indirect_write_op, 5'h0a, 8'h21, 0, 1, , , , , ptr_x, amode_post_inc),
            mk(direct_read_op, 5'h05, 8'ha5, 5, , , , , 16'h0020),
            mk(indirect_write_op, 5'h0a, 8'h20, 0, 2, , 1, , , ptr_x, amode_pre_dec),
            mk(indirect_read_op, 5'h03, 8'h3c, 3, , , 1, , , ptr_x, amode_post_inc),
            mk(idle_op, 5'h0a, 8'h21),
            mk(indirect_read_op, 5'h04, 8'h3c, 4, , , 1, , , ptr_x, amode_pre_dec),
            mk(idle_op, 5'h0a, 8'h20),
            mk(direct_write_op, 5'h06, 8'h3c, 0, 6, , , , 16'h0030),
            mk(direct_read_op, 5'h07, 8'h3c, 7, , , , , 16'h0030),
            mk(immediate_load_op, 5'h0c, 8'h40, 12, , , , 8'h40),
            mk(indirect_write_op, 5'h0c, 8'h40, 0, 1, , , , , ptr_y),
            mk(indirect_read_op, 5'h08, 8'ha5, 8, , , , , , ptr_y),
            mk(io_out_op, 5'h01, 8'ha5, 0, 1, , , , 16'h0005),
            mk(io_bit_clear_op, 5'h01, 8'ha5, 0, 0, 2, , , 16'h0005),
            mk(io_in_op, 5'h09, 8'ha1, 9, , , , , 16'h0005),
            mk(flag_to_bit_op, 5'h0e, 8'h08, 14, , 3),
            mk(push_op, 5'h11, 8'h5e, 0, 1, , 1),
            mk(pop_op, 5'h0d, 8'ha5, 13, , , 1),
            mk(idle_op, 5'h10, 8'h40)};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(5'h11, 8'h5f);
        rd(5'h10, 8'h00);
        foreach (rows[i]) run(rows[i]);
        rd(5'h11, 8'h5f);
        // each flag set then cleared alone
        st = 8'h40;
        for (int i = 0; i < 8; i++) begin
            st[i] = 1'b1;
            run(mk(flag_set_op, 5'h10, st, 0, 0, i[2:0]));
        end
        for (int i = 0; i < 8; i++) begin
            st[i] = 1'b0;
            run(mk(flag_clear_op, 5'h10, st, 0, 0, i[2:0]));
        end
        run(mk(global_irq_on_op, 5'h10, 8'h80));
        run(mk(global_irq_off_op, 5'h10, 8'h00));
        run(mk(sleep_op, 5'h10, 8'h00));
        run(mk(break_op, 5'h10, 8'h00));
        run(mk(watchdog_kick_op, 5'h10, 8'h00));
        // software status write in the cycle an op is taken
        for (int i = 0; i < 2; i++) begin
            sw_we <= 1'b1; sw_addr <= 5'h10; sw_wdata <= 8'h21; op_valid <= 1'b1;
            op <= i ? flag_clear_op : idle_op; op_bit <= 3'h0;
            @(posedge clk);
            sw_we <= 1'b0; op_valid <= 1'b0;
            @(posedge clk);
            rd(5'h10, i ? 8'h20 : 8'h21);
        end
        // software port: write, unmapped and read-only places
        wr(5'h01, 8'h77);
        rd(5'h01, 8'h77);
        rd(5'h1f, 8'h00);
        wr(5'h13, 8'hff);
        rd(5'h13, 8'h00);
        conclude();
    end
endmodule // tb_bit_flag_and_data_transfer_ops
